// File: hdl/fcsu_host.v
// host controller driving flash command sequences and status polling
// Functional notes
// RQ1 - non-read cycles are writes with hex codes
// RQ2 - single F0 write resets device
// RQ3 - program: AA, 55, A0, then data
// RQ4 - device ignores upper data in commands
// RQ5 - device ignores high address in commands
// RQ6 - sector chosen by high address bits
// RQ7 - address captured on later falling edge
// RQ8 - data captured on earlier rising edge
// RQ9 - ident: three writes with 90, then reads
// RQ10 - protect verify reads 00 or 01
// RQ11 - suspend only during sector erase
// RQ12 - resume only while suspended
// RQ13 - program poll shows inverse bit 7
// RQ14 - polling valid after last write edge
// RQ15 - protected program shows status briefly
// RQ16 - erase poll bit 0, then 1
// RQ17 - all-protected erase shows status briefly
// RQ18 - poll at program or erasing sector address
// RQ19 - take data only on next read
// RQ20 - recheck poll bit after timeout flag
// RQ21 - ready_busy_n low while busy
// RQ22 - ready_busy_n valid after final write
// RQ23 - sector erase window 50 us
// RQ24 - suspend reached within 20 us
// RQ25 - bad sequences return to array read
`include "fcsu_defs.vh"
module fcsu_host (
    input wire ref_clk_i, // 40 MHz clock
    input wire rst_b_i, // synchronous reset, active low
    input wire req_i, // start an operation, pulse
    input wire [2:0] op_i, // operation code
    input wire byte_mode_i, // 1 selects byte addressing
    input wire [17:0] addr_i, // program, sector or read address
    input wire [15:0] data_i, // program value
    input wire [15:0] dq_i, // flash data pins in
    input wire ready_busy_n_i, // flash ready/busy pin
    output reg busy_o, // operation in progress
    output reg done_o, // operation finished, pulse
    output reg fail_o, // timeout flag seen twice or poll limit reached, with done
    output reg [15:0] rdata_o, // read data, valid with done
    output reg [17:0] addr_o, // flash address pins
    output reg [15:0] dq_o, // flash data pins out
    output reg dq_oe_o, // high while driving data
    output reg ce_n_o, // chip select, active low
    output reg we_n_o, // write strobe, active low
    output reg oe_n_o, // output enable, active low
    output reg ready_o // synchronised ready/busy
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_STROBE = 3'h2;
    localparam ST_HOLD = 3'h3;
    localparam ST_NEXT = 3'h4;
    localparam ST_POLL = 3'h5;
    localparam ST_DONE = 3'h6;

    reg [2:0] state_reg;
    reg [2:0] op_reg;
    reg byte_reg;
    reg [17:0] addr_reg;
    reg [15:0] data_reg;
    reg [2:0] step_reg;
    reg [3:0] cnt_reg;
    reg is_read_reg;
    reg [1:0] poll_phase_reg;
    reg [15:0] poll_cnt_reg;
    reg [2:0] rb_sync_reg;

    // number of bus cycles each operation uses
    function [2:0] fcsu_len;
        input [2:0] op;
        begin
            case (op)
                `FCSU_OP_PROGRAM: fcsu_len = 3'h4; // [RQ3]
                `FCSU_OP_CHIP_ERASE: fcsu_len = 3'h6; // [RQ1]
                `FCSU_OP_SECTOR_ERASE: fcsu_len = 3'h6;
                `FCSU_OP_IDENT: fcsu_len = 3'h4; // [RQ9]
                default: fcsu_len = 3'h1; // [RQ2]
            endcase
        end
    endfunction

    // unlock address for cycle step, word or byte flavour
    function [17:0] fcsu_ua;
        input bm;
        input [2:0] step;
        begin
            if (step == 3'h1 || step == 3'h4) begin
                fcsu_ua = bm ? `FCSU_BADDR_B : `FCSU_WADDR_B;
            end else begin
                fcsu_ua = bm ? `FCSU_BADDR_A : `FCSU_WADDR_A;
            end
        end
    endfunction

    reg [17:0] cyc_addr;
    reg [7:0] cyc_data;
    reg cyc_read;
    reg [2:0] last_step;

    // address and data for the current bus cycle
    always @* begin
        cyc_addr = fcsu_ua(byte_reg, step_reg);
        cyc_data = `FCSU_CMD_UNLOCK1;
        cyc_read = 1'b0;
        last_step = fcsu_len(op_reg) - 3'h1;
        if (step_reg == 3'h1 || step_reg == 3'h4) begin
            cyc_data = `FCSU_CMD_UNLOCK2;
        end
        case (op_reg)
            `FCSU_OP_RESET: cyc_data = `FCSU_CMD_RESET; // [RQ2]
            `FCSU_OP_SUSPEND: cyc_data = `FCSU_CMD_SUSPEND; // [RQ11]
            `FCSU_OP_RESUME: cyc_data = `FCSU_CMD_RESUME; // [RQ12]
            `FCSU_OP_READ: begin
                cyc_addr = addr_reg;
                cyc_read = 1'b1;
            end
            `FCSU_OP_PROGRAM: begin
                if (step_reg == 3'h2) cyc_data = `FCSU_CMD_PROGRAM; // [RQ3]
                if (step_reg == 3'h3) begin
                    cyc_addr = addr_reg;
                    cyc_data = data_reg[7:0];
                end
            end
            `FCSU_OP_IDENT: begin
                if (step_reg == 3'h2) cyc_data = `FCSU_CMD_IDENT; // [RQ9]
                if (step_reg == 3'h3) begin
                    cyc_addr = addr_reg; // X00, X01/X02 or sector+offset
                    cyc_read = 1'b1; // [RQ10]
                end
            end
            default: begin
                if (step_reg == 3'h2) cyc_data = `FCSU_CMD_ERASE_SETUP;
                if (step_reg == 3'h5) begin
                    if (op_reg == `FCSU_OP_SECTOR_ERASE) begin
                        cyc_addr = addr_reg; // sector in high bits [RQ6]
                        cyc_data = `FCSU_CMD_SECTOR_ERASE;
                    end else begin
                        cyc_data = `FCSU_CMD_CHIP_ERASE;
                    end
                end
            end
        endcase
    end

    // poll only after program and erase; others finish at once
    wire need_poll = (op_reg == `FCSU_OP_PROGRAM) ||
                     (op_reg == `FCSU_OP_CHIP_ERASE) ||
                     (op_reg == `FCSU_OP_SECTOR_ERASE);
    // expected true value of the poll bit: written bit 7, or 1 for erase
    wire poll_true = (op_reg == `FCSU_OP_PROGRAM) ? data_reg[7] : 1'b1;

    // ready/busy passes three flops; a change counts when 2 and 3 agree
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            rb_sync_reg <= 3'h7;
            ready_o <= 1'b1;
        end else begin
            rb_sync_reg <= {rb_sync_reg[1:0], ready_busy_n_i};
            if (rb_sync_reg[1] == rb_sync_reg[2]) begin
                ready_o <= rb_sync_reg[2]; // [RQ21]
            end
        end
    end

    // main sequencer; strobe phases are whole cycles so address is set
    // before both strobes fall and data holds past the rising edge
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_IDLE;
            op_reg <= `FCSU_OP_RESET;
            byte_reg <= 1'b0;
            addr_reg <= 18'h00000;
            data_reg <= 16'h0000;
            step_reg <= 3'h0;
            cnt_reg <= 4'h0;
            is_read_reg <= 1'b0;
            poll_phase_reg <= 2'h0;
            poll_cnt_reg <= 16'h0000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            fail_o <= 1'b0;
            rdata_o <= 16'h0000;
            addr_o <= 18'h00000;
            dq_o <= 16'h0000;
            dq_oe_o <= 1'b0;
            ce_n_o <= 1'b1;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
        end else begin
            done_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (req_i) begin
                        op_reg <= op_i;
                        byte_reg <= byte_mode_i;
                        addr_reg <= addr_i;
                        data_reg <= data_i;
                        step_reg <= 3'h0;
                        poll_phase_reg <= 2'h0;
                        poll_cnt_reg <= 16'h0000;
                        fail_o <= 1'b0;
                        busy_o <= 1'b1;
                        state_reg <= ST_SETUP;
                        cnt_reg <= 4'h0;
                    end
                end
                ST_SETUP: begin
                    // drive address first; command upper byte left zero
                    addr_o <= cyc_addr; // [RQ5] [RQ7]
                    is_read_reg <= cyc_read;
                    if (cyc_read) begin
                        dq_oe_o <= 1'b0;
                    end else begin
                        dq_oe_o <= 1'b1; // [RQ1]
                        if (op_reg == `FCSU_OP_PROGRAM &&
                            step_reg == 3'h3) begin
                            dq_o <= data_reg;
                        end else begin
                            dq_o <= {8'h00, cyc_data}; // [RQ4]
                        end
                    end
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == `FCSU_SETUP_CYC - 4'h1) begin
                        cnt_reg <= 4'h0;
                        ce_n_o <= 1'b0;
                        we_n_o <= cyc_read;
                        oe_n_o <= ~cyc_read;
                        state_reg <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == `FCSU_STROBE_CYC - 4'h1) begin
                        cnt_reg <= 4'h0;
                        if (is_read_reg) begin
                            rdata_o <= dq_i;
                        end
                        // write strobe rises before chip select [RQ8]
                        we_n_o <= 1'b1;
                        oe_n_o <= 1'b1;
                        state_reg <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    ce_n_o <= 1'b1;
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == `FCSU_HOLD_CYC - 4'h1) begin
                        cnt_reg <= 4'h0;
                        dq_oe_o <= 1'b0;
                        state_reg <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (step_reg != last_step) begin
                        step_reg <= step_reg + 3'h1;
                        state_reg <= ST_SETUP;
                    end else if (need_poll) begin
                        // status valid from final write edge [RQ14]
                        addr_reg <= addr_reg; // poll at target [RQ18]
                        op_reg <= op_reg;
                        step_reg <= 3'h7;
                        state_reg <= ST_POLL;
                    end else begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_POLL: begin
                    // read cycle at the valid status address
                    case (poll_phase_reg)
                        2'h0: begin
                            addr_o <= addr_reg; // [RQ18]
                            ce_n_o <= 1'b0;
                            oe_n_o <= 1'b0;
                            poll_phase_reg <= 2'h1;
                        end
                        2'h1: poll_phase_reg <= 2'h2;
                        2'h2: begin
                            // counts whole polls so the limit is reachable
                            poll_cnt_reg <= poll_cnt_reg + 16'h0001;
                            ce_n_o <= 1'b1;
                            oe_n_o <= 1'b1;
                            poll_phase_reg <= 2'h0;
                            // [RQ13] [RQ16] true value means finished
                            if (dq_i[7] == poll_true) begin
                                poll_phase_reg <= 2'h3; // [RQ19]
                            end else if (dq_i[5]) begin
                                // recheck once after timeout [RQ20]
                                if (fail_o) begin
                                    state_reg <= ST_DONE;
                                end
                                fail_o <= 1'b1;
                            end else if (poll_cnt_reg ==
                                         `FCSU_POLL_LIMIT) begin
                                fail_o <= 1'b1;
                                state_reg <= ST_DONE;
                            end
                        end
                        default: begin
                            // fresh read after success gives valid data
                            op_reg <= `FCSU_OP_READ;
                            fail_o <= 1'b0;
                            step_reg <= 3'h0;
                            state_reg <= ST_SETUP;
                        end
                    endcase
                end
                default: begin
                    // every op ends here: busy clears, done pulses, back to idle; no reset command is sent
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// File: hdl/fcsu_defs.vh
// timing counts, command codes and unlock addresses for the flash host
`ifndef FCSU_DEFS_VH
`define FCSU_DEFS_VH
`define FCSU_CLK_MHZ 40
`define FCSU_SETUP_CYC 4'h2
`define FCSU_STROBE_CYC 4'h3
`define FCSU_HOLD_CYC 4'h2
`define FCSU_CMD_UNLOCK1 8'hAA
`define FCSU_CMD_UNLOCK2 8'h55
`define FCSU_CMD_RESET 8'hF0
`define FCSU_CMD_PROGRAM 8'hA0
`define FCSU_CMD_ERASE_SETUP 8'h80
`define FCSU_CMD_CHIP_ERASE 8'h10
`define FCSU_CMD_SECTOR_ERASE 8'h30
`define FCSU_CMD_SUSPEND 8'hB0
`define FCSU_CMD_RESUME 8'h30
`define FCSU_CMD_IDENT 8'h90
`define FCSU_WADDR_A 18'h00555
`define FCSU_WADDR_B 18'h002AA
`define FCSU_BADDR_A 18'h00AAA
`define FCSU_BADDR_B 18'h00555
`define FCSU_OP_RESET 3'h0
`define FCSU_OP_PROGRAM 3'h1
`define FCSU_OP_CHIP_ERASE 3'h2
`define FCSU_OP_SECTOR_ERASE 3'h3
`define FCSU_OP_SUSPEND 3'h4
`define FCSU_OP_RESUME 3'h5
`define FCSU_OP_IDENT 3'h6
`define FCSU_OP_READ 3'h7
`define FCSU_POLL_LIMIT 16'hFFFF
`endif

// File: dv/fcsu_host_assertions.sv
// checker for the flash host strobe, handshake and ready timing
module fcsu_host_chk (
    input wire logic ref_clk_i, // clock
    input wire logic rst_b_i, // reset, active low
    input wire logic req_i, // request
    input wire logic ready_busy_n_i, // flash ready line
    input wire logic busy_o, // busy
    input wire logic done_o, // done pulse
    input wire logic [17:0] addr_o, // flash address
    input wire logic [15:0] dq_o, // flash data out
    input wire logic dq_oe_o, // data drive enable
    input wire logic ce_n_o, // chip select
    input wire logic we_n_o, // write strobe
    input wire logic oe_n_o, // output enable
    input wire logic ready_o // synchronised ready
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    we_in_ce_a: assert property (!we_n_o |-> !ce_n_o && dq_oe_o)
        else $error("write strobe outside select");
    read_no_drive_a: assert property (!oe_n_o |-> !dq_oe_o && we_n_o)
        else $error("bus driven during read");
    we_width_a: assert property ($fell(we_n_o) |-> !we_n_o[*3] ##1 we_n_o)
        else $error("write strobe width wrong");
    addr_hold_a: assert property (
        !we_n_o |-> $stable(addr_o) && $stable(dq_o))
        else $error("address or data moved in strobe");
    data_setup_a: assert property ($fell(we_n_o) |-> $past(dq_oe_o))
        else $error("data not set up before strobe");
    ce_after_we_a: assert property (
        $rose(we_n_o) |-> !ce_n_o ##1 ce_n_o)
        else $error("select not released after strobe");
    req_start_a: assert property (req_i && !busy_o |=> busy_o)
        else $error("request not taken");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    rb_low_a: assert property (!ready_busy_n_i[*5] |-> !ready_o)
        else $error("ready not following busy");
    rb_high_a: assert property (ready_busy_n_i[*5] |-> ready_o)
        else $error("ready not following release");
endmodule
bind fcsu_host fcsu_host_chk i_fcsu_host_chk (.ref_clk_i, .rst_b_i, .req_i,
    .ready_busy_n_i, .busy_o, .done_o, .addr_o, .dq_o, .dq_oe_o, .ce_n_o,
    .we_n_o, .oe_n_o, .ready_o);

// File: dv/fcsu_flash_model.sv
// behavioural flash device seen by the host controller
module fcsu_flash_model #(
    parameter logic [5:0] PROT_SEC = 6'h07, // protected sector
    parameter logic [15:0] MAKER = 16'h005A, // arbitrary maker code
    parameter logic [15:0] PART = 16'h00C3, // arbitrary part code
    parameter int PROG_T = 10, // program time in 100 ns ticks
    parameter int ERASE_T = 50 // erase time in 100 ns ticks
) (
    input wire logic byte_mode_i, // byte addressing
    input wire logic [17:0] addr_i, // address pins
    input wire logic [15:0] dq_w_i, // data written by host
    input wire logic ce_n_i, // chip select
    input wire logic we_n_i, // write strobe
    input wire logic oe_n_i, // output enable
    output logic [15:0] dq_o, // data read by host
    output logic ready_busy_n_o // ready/busy, pulled up
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [logic [17:0]];
    logic [17:0] wa, pa, m, k1, k2;
    logic [15:0] pdat, last = 16'h0000;
    logic [7:0] d;
    logic [5:0] sa;
    logic run = 1'h0, susp = 1'h0, ident = 1'h0, prot = 1'h0;
    int cnt = 0, mode = 0, left = 0;
    // only low address bits take part in unlock matching
    assign m = byte_mode_i ? 18'h00FFF : 18'h007FF;
    assign k1 = byte_mode_i ? 18'h00AAA : 18'h00555;
    assign k2 = byte_mode_i ? 18'h00555 : 18'h002AA;
    // suspend releases the line even though the erase is unfinished
    assign ready_busy_n_o = !(run && !susp);
    function automatic logic hit(input logic [17:0] k);
        return ((wa ^ k) & m) == 18'h00000;
    endfunction
    task automatic go(input int md, input int t);
        cnt = 0;
        mode = md;
        left = t;
        run = 1'h1;
    endtask
    // address taken on the later falling edge
    always @(negedge we_n_i) wa = addr_i;
    // command decoder on the earlier rising edge
    always @(posedge we_n_i) if (!ce_n_i) begin
        d = dq_w_i[7:0];
        if (run && !susp) begin
            if (d == 8'hB0 && mode == 2) susp = 1'h1;
        end else if (d == 8'hF0) begin
            cnt = 0;
            ident = 1'h0;
        end else if (susp && cnt == 0 && d == 8'h30) susp = 1'h0;
        else case (cnt)
            0: cnt = (d == 8'hAA && hit(k1)) ? 1 : 0;
            1: cnt = (d == 8'h55 && hit(k2)) ? 2 : 0;
            2: begin
                ident = ident || (hit(k1) && d == 8'h90);
                cnt = !hit(k1) ? 0 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
            end
            3: begin
                pa = wa;
                pdat = dq_w_i;
                prot = wa[17:12] == PROT_SEC;
                go(1, prot ? 20 : PROG_T);
            end
            4: cnt = (d == 8'hAA && hit(k1)) ? 5 : 0;
            5: cnt = (d == 8'h55 && hit(k2)) ? 6 : 0;
            default: begin
                sa = wa[17:12];
                prot = d == 8'h30 && sa == PROT_SEC;
                if (d == 8'h10 && hit(k1)) go(3, ERASE_T);
                else if (d == 8'h30) go(2, prot ? 1000 : 500 + ERASE_T);
                else cnt = 0;
            end
        endcase
    end
    // algorithm timer, frozen while suspended
    always #100 if (run && !susp) begin
        left = left - 1;
        if (left == 0) begin
            run = 1'h0;
            if (mode == 1 && !prot) mem[pa] = pdat;
            if (mode == 3) mem.delete();
        end
    end
    // read path; a released bus shows the inverse of its last value
    always @* begin
        if (ce_n_i || oe_n_i) dq_o = ~last;
        else if (run && !susp)
            dq_o = mode == 1 ? {8'h00, ~pdat[7], 7'h00} : 16'h0000;
        else if (susp && addr_i[17:12] == sa) dq_o = 16'h0080;
        else if (ident && addr_i[7:0] == 8'h00) dq_o = MAKER;
        else if (ident && addr_i[7:0] == {6'h00, byte_mode_i, !byte_mode_i})
            dq_o = PART;
        else if (ident && addr_i[2:0] == {byte_mode_i, !byte_mode_i, 1'h0})
            dq_o = {15'h0000, addr_i[17:12] == PROT_SEC};
        else dq_o = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
    end
    always @(posedge oe_n_i) last = dq_o;
endmodule

// File: dv/fcsu_host_tb.sv
// self-checking bench for the flash host controller
`include "fcsu_defs.vh"
module fcsu_host_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] MAKER = 16'h005A; // arbitrary value
    localparam logic [15:0] PART = 16'h00C3; // arbitrary value
    logic ref_clk_i = 1'h0, rst_b_i = 1'h0, req_i = 1'h0, byte_mode_i = 1'h0;
    logic [2:0] op_i = 3'h0;
    logic [17:0] addr_i = 18'h00000, addr_o, pa;
    logic [15:0] data_i = 16'h0000, dq_i, rdata_o, dq_o, pd;
    logic busy_o, done_o, fail_o, dq_oe_o, ce_n_o, we_n_o, oe_n_o, ready_o;
    logic ready_busy_n_i, saw_busy;
    logic [16:0] exp_q[$];
    logic [16:0] e;
    int bad_count = 0, cmp_count = 0;
    fcsu_host i_fcsu_host (.ref_clk_i, .rst_b_i, .req_i, .op_i, .byte_mode_i,
        .addr_i, .data_i, .dq_i, .ready_busy_n_i, .busy_o, .done_o, .fail_o,
        .rdata_o, .addr_o, .dq_o, .dq_oe_o, .ce_n_o, .we_n_o, .oe_n_o,
        .ready_o);
    fcsu_flash_model #(.MAKER(MAKER), .PART(PART)) i_fcsu_flash_model (
        .byte_mode_i, .addr_i(addr_o), .dq_w_i(dq_oe_o ? dq_o : 16'hFFFF),
        .ce_n_i(ce_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o), .dq_o(dq_i),
        .ready_busy_n_o(ready_busy_n_i));
    always #12.5 ref_clk_i = ~ref_clk_i;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s %h vs %h", $time, msg, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one request; the expectation waits in the queue for its done pulse
    task automatic do_op(input logic [2:0] op, input logic [17:0] a,
                         input logic [15:0] d, input logic [16:0] ex);
        int n;
        n = 0;
        exp_q.push_back(ex);
        saw_busy = 1'h0;
        op_i <= op;
        addr_i <= a;
        data_i <= d;
        req_i <= 1'h1;
        @(posedge ref_clk_i);
        req_i <= 1'h0;
        while (done_o !== 1'h1 && n < 20000) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 20000) bad_count++;
    endtask
    // watcher: each done pulse consumes the oldest expectation
    always @(posedge ref_clk_i) begin
        if (ready_o === 1'h0) saw_busy = 1'h1;
        if (done_o === 1'h1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 17'h00000;
            check({15'h0000, fail_o}, 16'h0000, "fail flag");
            if (e[16]) check(rdata_o, e[15:0], "read data");
        end
    end
    // every operation in both addressing modes, random data and address
    initial begin
        void'($urandom(19997));
        repeat (3) @(posedge ref_clk_i);
        rst_b_i <= 1'h1;
        @(posedge ref_clk_i);
        for (int bm = 0; bm < 2; bm++) begin
            byte_mode_i <= bm[0];
            pa = {6'h01, 12'($urandom)};
            pd = 16'($urandom);
            do_op(`FCSU_OP_READ, pa, pd, {1'h1, 16'hFFFF});
            do_op(`FCSU_OP_PROGRAM, pa, pd, {1'h1, pd});
            check({15'h0000, saw_busy}, 16'h0001, "busy");
            do_op(`FCSU_OP_IDENT, 18'h00000, pd, {1'h1, MAKER});
            do_op(`FCSU_OP_IDENT, {16'h0000, bm[0], !bm[0]}, pd,
                  {1'h1, PART});
            do_op(`FCSU_OP_IDENT, {6'h07, 9'h000, bm[0], !bm[0], 1'h0}, pd,
                  {1'h1, 16'h0001});
            do_op(`FCSU_OP_RESET, pa, pd, 17'h00000);
            do_op(`FCSU_OP_READ, pa, pd, {1'h1, pd});
            do_op(`FCSU_OP_PROGRAM, {6'h07, 12'h123}, pd | 16'h0080,
                  {1'h1, 16'hFFFF});
            do_op(`FCSU_OP_SUSPEND, pa, pd, 17'h00000);
            do_op(`FCSU_OP_RESUME, pa, pd, 17'h00000);
            do_op(`FCSU_OP_SECTOR_ERASE, {6'h02, 12'h000}, pd,
                  {1'h1, 16'hFFFF});
            check({15'h0000, saw_busy}, 16'h0001, "erase busy");
            do_op(`FCSU_OP_READ, pa, pd, {1'h1, pd});
            do_op(`FCSU_OP_CHIP_ERASE, pa, pd, {1'h1, 16'hFFFF});
            do_op(`FCSU_OP_READ, pa, pd, {1'h1, 16'hFFFF});
        end
        @(posedge ref_clk_i);
        summarize();
    end
    // watchdog set far past the expected six thousand or so cycles
    initial begin
        #(60000 * 25);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
endmodule
